// File: design/rpio_top.sv
// Purpose: Remote parallel input and status output control
// Assumes: AXI4-Lite master holds payloads until taken
// Notes: Config registers are shadows until commit
`timescale 1ns/1ps
`default_nettype none
`include "rpio_consts.svh"
module rpio_top
  import rpio_pkg::*;
#(
  parameter int unsigned N_IN = `RPIO_N_IN,
  parameter int unsigned N_OUT = `RPIO_N_OUT,
  parameter int unsigned REPEAT_CYC = `RPIO_REPEAT_CYC,
  parameter int unsigned DEB_CYC = `RPIO_DEBOUNCE_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [9:0] remoteIn,
  input wire rpio_stat_type txStatus,
  output rpio_req_type txRequest,
  output logic hostResetReq,
  output logic [15:0] remoteOut,
  output logic [15:0] remoteOutEn
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic remoteMode;
    logic [9:0][11:0] inShadow;
    logic [9:0][11:0] inCfg;
    logic [15:0][12:0] outShadow;
    logic [15:0][12:0] outCfg;
    logic [9:0] prevLvl;
    logic [9:0] togState;
    logic [9:0] lvlActive;
    logic [31:0] repCnt;
    logic [3:0] repOwner;
    rpio_req_type req;
    logic hostReset;
    logic [15:0] outLvl;
    logic [15:0] outEn;
  } rpio_state_type;

  rpio_state_type state_r, state_nxt;
  logic [9:0] pinLvl;

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_in
      rpio_debounce #(.STABLE_CYC(DEB_CYC)) u_deb (
        .clock(clock),
        .reset(reset),
        .pin(remoteIn[gi]),
        .level(pinLvl[gi])
      );
    end
  endgenerate

  // Decode a channel mode into its active level
  function automatic logic modeActiveHigh(input logic [3:0] m);
    case (rpio_mode_type'(m))
      MD_RISE_ON, MD_RISE_OFF, MD_RISE_TOG, MD_RISE_ON_FALL_OFF,
      MD_HIGH_INC, MD_HIGH_DEC: modeActiveHigh = 1'b1;
      default: modeActiveHigh = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    wmerge = r;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] merged;
    logic [7:0] ra;
    logic [3:0] idx;
    logic rising;
    logic falling;
    logic selLvl;
    logic pwrFound;
    logic [3:0] fn;
    logic [3:0] md;
    logic srcTrue;
    logic drvLow;
    logic commitNow;
    commitNow = 1'b0;
    merged = '0;
    ra = '0;
    idx = '0;
    rising = 1'b0;
    falling = 1'b0;
    selLvl = 1'b0;
    pwrFound = 1'b0;
    fn = '0;
    md = '0;
    srcTrue = 1'b0;
    drvLow = 1'b0;
    state_nxt = state_r;
    state_nxt.req = '0;
    // Write channel
    if (s_axi_awvalid && !state_r.awHeld) begin
      state_nxt.awHeld = 1'b1;
      state_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_r.wHeld) begin
      state_nxt.wHeld = 1'b1;
      state_nxt.wData = s_axi_wdata;
      state_nxt.wStrb = s_axi_wstrb;
    end
    if (state_r.awHeld && state_r.wHeld && !state_r.bValid) begin
      state_nxt.awHeld = 1'b0;
      state_nxt.wHeld = 1'b0;
      state_nxt.bValid = 1'b1;
      state_nxt.bResp = 2'b00;
      idx = state_r.awAddr[5:2];
      if (state_r.awAddr == `RPIO_A_CTRL) begin
        merged = wmerge({31'h0, state_r.remoteMode}, state_r.wData,
          state_r.wStrb);
        state_nxt.remoteMode = merged[0];
      end else if (state_r.awAddr == `RPIO_A_COMMIT) begin
        // Shadows move live together; edge history kept to avoid events
        if (state_r.wStrb[0] && state_r.wData[0]) begin
          commitNow = 1'b1;
          state_nxt.inCfg = state_r.inShadow;
          state_nxt.outCfg = state_r.outShadow;
          state_nxt.togState = '0;
          state_nxt.lvlActive = '0;
        end
      end else if (state_r.awAddr[7:6] == 2'b01 && idx < 4'd10) begin
        merged = wmerge({20'h0, state_r.inShadow[idx]}, state_r.wData,
          state_r.wStrb);
        state_nxt.inShadow[idx] = merged[11:0];
      end else if (state_r.awAddr[7:6] == 2'b10) begin
        merged = wmerge({19'h0, state_r.outShadow[idx]}, state_r.wData,
          state_r.wStrb);
        state_nxt.outShadow[idx] = merged[12:0];
      end else begin
        state_nxt.bResp = 2'b10;
      end
    end
    if (state_r.bValid && s_axi_bready) begin
      state_nxt.bValid = 1'b0;
    end
    // Read channel
    if (s_axi_arvalid && !state_r.rValid) begin
      ra = s_axi_araddr;
      idx = ra[5:2];
      state_nxt.rValid = 1'b1;
      state_nxt.rResp = 2'b00;
      state_nxt.rData = '0;
      if (ra == `RPIO_A_CTRL) begin
        state_nxt.rData = {31'h0, state_r.remoteMode};
      end else if (ra == `RPIO_A_INLVL) begin
        state_nxt.rData = {22'h0, pinLvl};
      end else if (ra == `RPIO_A_OUTLVL) begin
        state_nxt.rData = {16'h0, state_r.outLvl};
      end else if (ra == `RPIO_A_STAT) begin
        state_nxt.rData = {22'h0, state_r.togState};
      end else if (ra == `RPIO_A_COMMIT) begin
        state_nxt.rData = '0;
      end else if (ra[7:6] == 2'b01 && idx < 4'd10) begin
        state_nxt.rData = {20'h0, state_r.inShadow[idx]};
      end else if (ra[7:6] == 2'b10) begin
        state_nxt.rData = {19'h0, state_r.outShadow[idx]};
      end else begin
        state_nxt.rResp = 2'b10;
      end
    end else if (state_r.rValid && s_axi_rready) begin
      state_nxt.rValid = 1'b0;
    end
    // ---------------------------------------------------------------
    // Input channels
    // ---------------------------------------------------------------
    state_nxt.prevLvl = pinLvl;
    state_nxt.hostReset = 1'b0;
    for (int c = 0; c < 10; c++) begin
      fn = state_r.inCfg[c][`RPIO_F_FUNC];
      md = state_r.inCfg[c][`RPIO_F_MODE];
      rising = pinLvl[c] && !state_r.prevLvl[c];
      falling = !pinLvl[c] && state_r.prevLvl[c];
      selLvl = modeActiveHigh(md) ? pinLvl[c] : !pinLvl[c];
      state_nxt.lvlActive[c] = selLvl;
      // Local mode and unassigned channels do nothing
      if (state_r.remoteMode && fn != 4'(FN_NONE) && !commitNow) begin
        case (rpio_mode_type'(md))
          MD_RISE_ON, MD_FALL_ON, MD_RISE_OFF, MD_FALL_OFF: begin
            // One-shot on the selected direction
            if ((modeActiveHigh(md) && rising) ||
                (!modeActiveHigh(md) && falling)) begin
              state_nxt.togState[c] = (md == 4'(MD_RISE_ON) ||
                md == 4'(MD_FALL_ON));
            end
          end
          MD_RISE_TOG, MD_FALL_TOG: begin
            if ((md == 4'(MD_RISE_TOG) && rising) ||
                (md == 4'(MD_FALL_TOG) && falling)) begin
              state_nxt.togState[c] = !state_r.togState[c];
            end
          end
          MD_RISE_ON_FALL_OFF, MD_FALL_ON_RISE_OFF: begin
            if (rising || falling) begin
              state_nxt.togState[c] = selLvl;
            end
          end
          default: begin
            state_nxt.togState[c] = selLvl;
          end
        endcase
      end
    end
    // Actions on a change of channel state
    for (int c = 0; c < 10; c++) begin
      fn = state_r.inCfg[c][`RPIO_F_FUNC];
      md = state_r.inCfg[c][`RPIO_F_MODE];
      rising = state_nxt.togState[c] && !state_r.togState[c];
      falling = !state_nxt.togState[c] && state_r.togState[c];
      // One-shot modes fire each selected edge even if already set
      if (state_r.remoteMode && md < 4'(MD_FALL_TOG) &&
          ((modeActiveHigh(md) && pinLvl[c] && !state_r.prevLvl[c]) ||
           (!modeActiveHigh(md) && !pinLvl[c] && state_r.prevLvl[c]))) begin
        rising = (md == 4'(MD_RISE_ON) || md == 4'(MD_FALL_ON));
        falling = !rising;
      end
      // Paired edges request on every edge, even if state unchanged
      if (state_r.remoteMode && md[3:1] == 3'h3 &&
          pinLvl[c] != state_r.prevLvl[c]) begin
        rising = modeActiveHigh(md) == pinLvl[c];
        falling = !rising;
      end
      // Clearing states on commit must not look like an edge
      if (commitNow) begin
        rising = 1'b0;
        falling = 1'b0;
      end
      case (rpio_func_type'(fn))
        FN_RF: begin
          state_nxt.req.rfOn = state_nxt.req.rfOn | rising;
          state_nxt.req.rfOff = state_nxt.req.rfOff | falling;
        end
        FN_RESET: begin
          state_nxt.req.sysReset = state_nxt.req.sysReset | rising;
        end
        FN_REBOOT: begin
          state_nxt.hostReset = state_nxt.hostReset | rising;
        end
        FN_EXCITER: begin
          // Argument bit 0 picks B
          if (rising && state_r.inCfg[c][4]) begin
            state_nxt.req.selB = 1'b1;
          end else if (rising) begin
            state_nxt.req.selA = 1'b1;
          end
        end
        FN_CHANGEOVER: begin
          if (md == 4'(MD_RISE_TOG) || md == 4'(MD_FALL_TOG)) begin
            state_nxt.req.coToggle = state_nxt.req.coToggle |
              rising | falling;
          end else begin
            state_nxt.req.coSet = state_nxt.req.coSet | rising;
            state_nxt.req.coClear = state_nxt.req.coClear | falling;
          end
        end
        FN_PRESET: begin
          if (rising && !state_nxt.req.presetGo) begin
            state_nxt.req.presetGo = 1'b1;
            state_nxt.req.presetSel = state_r.inCfg[c][`RPIO_F_ARG];
          end
        end
        default: begin
        end
      endcase
    end
    // Power stepping, lowest active channel wins
    for (int c = 0; c < 10; c++) begin
      if (!pwrFound && state_r.togState[c] &&
          state_r.inCfg[c][`RPIO_F_FUNC] == 4'(FN_POWER)) begin
        pwrFound = 1'b1;
        idx = 4'(c);
      end
    end
    if (!pwrFound || !state_r.remoteMode) begin
      state_nxt.repCnt = '0;
      state_nxt.repOwner = 4'hf;
    end else begin
      md = state_r.inCfg[idx][`RPIO_F_MODE];
      if (state_r.repOwner != idx ||
          state_r.repCnt >= 32'(REPEAT_CYC - 1)) begin
        state_nxt.repCnt = '0;
        state_nxt.req.powerUp = (md != 4'(MD_HIGH_DEC) &&
          md != 4'(MD_LOW_DEC));
        state_nxt.req.powerDown = !state_nxt.req.powerUp;
      end else begin
        state_nxt.repCnt = state_r.repCnt + 32'h1;
      end
      state_nxt.repOwner = idx;
    end
    // ---------------------------------------------------------------
    // Output channels
    // ---------------------------------------------------------------
    for (int o = 0; o < 16; o++) begin
      srcTrue = 1'b0;
      drvLow = 1'b1;
      case (rpio_src_type'(state_r.outCfg[o][`RPIO_F_OSRC]))
        SRC_REMOTE: srcTrue = state_r.remoteMode;
        SRC_RF: srcTrue = txStatus.rfOn;
        SRC_PRESET: begin
          srcTrue = txStatus.preset == state_r.outCfg[o][7:4];
          drvLow = srcTrue;
        end
        SRC_EXCITER: begin
          srcTrue = txStatus.exciterB == state_r.outCfg[o][4];
          drvLow = srcTrue;
        end
        SRC_CHANGEOVER: srcTrue = txStatus.changeover;
        SRC_ALARM: srcTrue = txStatus.alarms[state_r.outCfg[o][11:4]];
        SRC_AUDIO: srcTrue = txStatus.audioActive[state_r.outCfg[o][5:4]];
        default: drvLow = 1'b0;
      endcase
      // Polarity bit set means low when false
      state_nxt.outLvl[o] = srcTrue == state_r.outCfg[o][`RPIO_F_OPOL];
      state_nxt.outEn[o] = !(drvLow && !state_nxt.outLvl[o]);
      if (!state_nxt.outEn[o]) begin
        state_nxt.outLvl[o] = 1'b0;
      end else if (drvLow) begin
        state_nxt.outLvl[o] = 1'b1;
      end else begin
        state_nxt.outLvl[o] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= '0;
      state_r.repOwner <= 4'hf;
      state_r.outEn <= 16'hffff;
      state_r.outLvl <= 16'hffff;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign s_axi_awready = !state_r.awHeld;
  assign s_axi_wready = !state_r.wHeld;
  assign s_axi_bvalid = state_r.bValid;
  assign s_axi_bresp = state_r.bResp;
  assign s_axi_arready = !state_r.rValid;
  assign s_axi_rvalid = state_r.rValid;
  assign s_axi_rdata = state_r.rData;
  assign s_axi_rresp = state_r.rResp;
  assign txRequest = state_r.req;
  assign hostResetReq = state_r.hostReset;
  assign remoteOut = state_r.outLvl;
  assign remoteOutEn = state_r.outEn;
endmodule
`default_nettype wire

// File: design/rpio_consts.svh
// Purpose: Constants for the remote parallel I/O control block
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes: Register offsets are byte addresses
//
// What this block does
// - Ten input channels, each with function, polarity mode and readable level.
// - Inputs are ignored while control is local; acted on only in remote.
// - Input with no function never changes transmitter operation.
// - RF on/off input issues the same RF on or off request as local.
// - Reset input raises a system reset request like the local reset.
// - Host reboot input asserts hardware reset to the embedded host computer.
// - Exciter select input makes exciter A or B the operating exciter.
// - Auto changeover input in toggle mode inverts changeover enable per activation.
// - Power up/down input steps 1% and repeats every half second while held.
// - Several active power inputs: only the lowest index channel is obeyed.
// - Preset input makes its named preset the active preset.
// - Single-action modes act on high/rising or low/falling as selected.
// - Toggle modes alternate activated/deactivated on each selected edge.
// - Paired-edge modes activate on one edge, deactivate on the other.
// - Level modes act while the pin holds the selected level.
// - Sixteen output channels with source, polarity and readable level.
// - Remote-enabled output is active exactly while remote control is enabled.
// - Preset outputs drive low only for the active preset, else open collector.
// - Exciter outputs drive low for the operating exciter, else open collector.
// - Audio output drives low while its selected audio path is active.
// - Each output other than preset, exciter and no-source selectable as low-when-true or low-when-false.
// - Any alarm selectable as output source, active while alarm present.
`ifndef RPIO_CONSTS_SVH
`define RPIO_CONSTS_SVH

`define RPIO_N_IN 10
`define RPIO_N_OUT 16
// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define RPIO_A_CTRL 8'h00
`define RPIO_A_INLVL 8'h04
`define RPIO_A_OUTLVL 8'h08
`define RPIO_A_STAT 8'h0c
`define RPIO_A_COMMIT 8'h10
`define RPIO_A_INCFG 8'h40
`define RPIO_A_OUTCFG 8'h80
// ---------------------------------------------------------------
// Field layout
// ---------------------------------------------------------------
`define RPIO_F_FUNC 3:0
`define RPIO_F_ARG 7:4
`define RPIO_F_MODE 11:8
`define RPIO_F_OSRC 3:0
`define RPIO_F_OARG 11:4
`define RPIO_F_OPOL 12
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RPIO_CLK_HZ 40000000
`define RPIO_REPEAT_MS 500
`define RPIO_DEBOUNCE_US 10
`define RPIO_REPEAT_CYC ((`RPIO_CLK_HZ / 1000) * `RPIO_REPEAT_MS)
`define RPIO_DEBOUNCE_CYC ((`RPIO_CLK_HZ / 1000000) * `RPIO_DEBOUNCE_US)

`endif

// File: design/rpio_pkg.sv
// Purpose: Types for the remote parallel I/O control block
// Assumes: Used with rpio_consts.svh
// Notes: Enumerations follow the configuration encodings
package rpio_pkg;
  typedef enum logic [3:0] {
    FN_NONE, FN_RF, FN_RESET, FN_REBOOT, FN_EXCITER, FN_CHANGEOVER,
    FN_POWER, FN_PRESET
  } rpio_func_type;
  typedef enum logic [3:0] {
    MD_RISE_ON, MD_FALL_ON, MD_RISE_OFF, MD_FALL_OFF, MD_FALL_TOG,
    MD_RISE_TOG, MD_RISE_ON_FALL_OFF, MD_FALL_ON_RISE_OFF,
    MD_HIGH_INC, MD_LOW_INC, MD_HIGH_DEC, MD_LOW_DEC
  } rpio_mode_type;
  typedef enum logic [3:0] {
    SRC_NONE, SRC_REMOTE, SRC_RF, SRC_PRESET, SRC_EXCITER,
    SRC_CHANGEOVER, SRC_ALARM, SRC_AUDIO
  } rpio_src_type;
  typedef struct packed {
    logic rfOn;
    logic rfOff;
    logic sysReset;
    logic selA;
    logic selB;
    logic coToggle;
    logic coSet;
    logic coClear;
    logic powerUp;
    logic powerDown;
    logic presetGo;
    logic [3:0] presetSel;
  } rpio_req_type;
  typedef struct packed {
    logic rfOn;
    logic exciterB;
    logic changeover;
    logic [3:0] preset;
    logic [3:0] audioActive;
    logic [255:0] alarms;
  } rpio_stat_type;
  typedef struct packed {
    logic [11:0] cfg;
  } rpio_incfg_type;
  typedef struct packed {
    logic fltA;
    logic fltB;
    logic stable;
    logic [15:0] count;
  } rpio_deb_type;
endpackage

// File: design/rpio_debounce.sv
// Purpose: Three-stage synchroniser and debounce for one pin
// Assumes: Pin is asynchronous to clock
// Notes: Change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
`include "rpio_consts.svh"
module rpio_debounce
  import rpio_pkg::*;
#(
  parameter int unsigned STABLE_CYC = `RPIO_DEBOUNCE_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic pin,
  output logic level
);
  logic sync1_r;
  rpio_deb_type state_r, state_nxt;

  // First stage read by the second stage only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_r <= 1'b0;
      state_r <= '0;
    end else begin
      sync1_r <= pin;
      state_r <= state_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.fltA = sync1_r;
    state_nxt.fltB = state_r.fltA;
    // Agreement of stages two and three before counting
    if (state_r.fltA == state_r.fltB && state_r.fltB != state_r.stable) begin
      if (state_r.count >= 16'(STABLE_CYC - 1)) begin
        state_nxt.stable = state_r.fltB;
        state_nxt.count = '0;
      end else begin
        state_nxt.count = state_r.count + 16'h0001;
      end
    end else begin
      state_nxt.count = '0;
    end
  end

  assign level = state_r.stable;
endmodule
`default_nettype wire

// File: test/rpio_props.sv
// Purpose: Port timing checks for rpio_top
// Assumes: One clock domain, async active high reset
// Notes: Power and preset pulses may repeat, so kept out of the delay check
`timescale 1ns/1ps
`default_nettype none
module rpio_props
  import rpio_pkg::*;
#(
  parameter int unsigned DEB_CYC = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [9:0] remoteIn,
  input wire rpio_req_type txRequest,
  input wire logic hostResetReq
);
  // ----
  // Cycles since any pin moved
  // ----
  logic [9:0] prevIn_r;
  logic [7:0] since_r;
  logic edgeReq;
  assign edgeReq = txRequest.rfOn | txRequest.rfOff | txRequest.sysReset |
    txRequest.selA | txRequest.selB | txRequest.coToggle | hostResetReq;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prevIn_r <= 10'h000;
      since_r <= 8'hff;
    end else begin
      prevIn_r <= remoteIn;
      if (remoteIn != prevIn_r) since_r <= 8'h00;
      else if (since_r != 8'hff) since_r <= since_r + 8'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Too early means no debounce, too late or none means a spurious event
  chk_edge_delay: assert property (
    edgeReq |-> since_r >= DEB_CYC && since_r <= DEB_CYC + 12)
    else $error("pin request outside debounce window");
  chk_rf_exclusive: assert property (
    txRequest.rfOn |-> !txRequest.rfOff) else $error("rf on and off together");
  chk_sel_exclusive: assert property (
    txRequest.selA |-> !txRequest.selB) else $error("both exciters picked");
  chk_power_single: assert property (
    txRequest.powerUp |-> !txRequest.powerDown) else $error("power up and down");
  chk_power_spacing: assert property (
    txRequest.powerUp |=> !txRequest.powerUp [*8]) else $error("power step early");
  chk_host_pulse: assert property (
    hostResetReq |=> !hostResetReq) else $error("host reset pulse too long");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  chk_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  chk_bresp_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule
bind rpio_top rpio_props #(.DEB_CYC(DEB_CYC)) rpio_props_inst (.clock, .reset,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .remoteIn, .txRequest, .hostResetReq);
`default_nettype wire

// File: test/rpio_site_unit.sv
// Purpose: Site remote control unit with contact closures
// Assumes: Pull-ups on both sides of every contact
// Notes: An open collector output reads high through its pull-up
`timescale 1ns/1ps
`default_nettype none
module rpio_site_unit (
  input wire logic [9:0] contactClosed,
  output logic [9:0] remoteIn,
  input wire logic [15:0] remoteOut,
  input wire logic [15:0] remoteOutEn,
  output logic [15:0] pinLevel
);
  // Closed contact pulls low, open one floats to the pull-up
  assign remoteIn = ~contactClosed;
  assign pinLevel = remoteOut | remoteOutEn;
endmodule
`default_nettype wire

// File: test/tb_remote_parallel_io_control.sv
// Purpose: Self-checking bench for rpio_top
// Assumes: Debounce and repeat counts shortened for speed
// Notes: Inputs via site unit model; AXI taken at rising edge
`timescale 1ns/1ps
`default_nettype none
`include "rpio_consts.svh"
module tb_remote_parallel_io_control
  import rpio_pkg::*;
;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  logic [9:0] remoteIn;
  logic [9:0] closed = 10'h000;
  rpio_stat_type txStatus = '0;
  rpio_req_type txRequest;
  logic hostResetReq;
  logic [15:0] remoteOut;
  logic [15:0] remoteOutEn;
  logic [15:0] pinLevel;
  logic [15:0] acc;
  logic [1:0] lastResp;
  logic [31:0] lastData;
  int num_errors = 0;
  int checked = 0;
  int n;
  // ----
  // Rows: input config, start and end level, expected requests
  // ----
  logic [29:0] inRows [20] = '{{12'h001, 2'h1, 16'h8000},
    {12'h101, 2'h2, 16'h8000}, {12'h201, 2'h1, 16'h4000},
    {12'h301, 2'h2, 16'h4000}, {12'h401, 2'h2, 16'h8000},
    {12'h501, 2'h1, 16'h8000}, {12'h601, 2'h1, 16'h8000},
    {12'h601, 2'h2, 16'h4000}, {12'h701, 2'h2, 16'h8000},
    {12'h102, 2'h2, 16'h2000}, {12'h103, 2'h2, 16'h0001},
    {12'h104, 2'h2, 16'h1000}, {12'h114, 2'h2, 16'h0800},
    {12'h405, 2'h2, 16'h0400}, {12'h806, 2'h1, 16'h0080},
    {12'h906, 2'h2, 16'h0080}, {12'ha06, 2'h1, 16'h0040},
    {12'hb06, 2'h2, 16'h0040}, {12'h837, 2'h1, 16'h0026},
    {12'h100, 2'h2, 16'h0000}};
  logic [13:0] outRows [10] = '{{13'h0001, 1'h0}, {13'h1001, 1'h1},
    {13'h0002, 1'h0}, {13'h0023, 1'h0}, {13'h0013, 1'h1}, {13'h0014, 1'h0},
    {13'h0005, 1'h1}, {13'h0056, 1'h0}, {13'h0066, 1'h1}, {13'h0017, 1'h0}};
  always #12.5 clock = ~clock;
  rpio_top #(.REPEAT_CYC(50), .DEB_CYC(2)) rpio_top_inst (.clock, .reset,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .remoteIn, .txStatus, .txRequest, .hostResetReq, .remoteOut, .remoteOutEn);
  rpio_site_unit rpio_site_unit_inst (.contactClosed(closed), .remoteIn,
    .remoteOut, .remoteOutEn, .pinLevel);
  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_up();
    num_errors++;
    wrap_up();
  endtask
  // Each channel is taken at the rising edge where valid and ready meet
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic tb;
    int k;
    k = 0;
    tb = 1'h0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!tb) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      tb = s_axi_bvalid && s_axi_bready;
      if (tb) lastResp = s_axi_bresp;
      if (tb) s_axi_bready <= 1'h0;
      k++;
      if (k > 40) give_up();
    end
  endtask
  task automatic axr(input logic [7:0] a);
    logic tr;
    int k;
    k = 0;
    tr = 1'h0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tr) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      tr = s_axi_rvalid && s_axi_rready;
      if (tr) lastData = s_axi_rdata;
      if (tr) lastResp = s_axi_rresp;
      if (tr) s_axi_rready <= 1'h0;
      k++;
      if (k > 40) give_up();
    end
  endtask
  task automatic cfg_in(input int ch, input logic [11:0] c);
    axw(`RPIO_A_INCFG + 8'(4 * ch), {20'h0, c});
    axw(`RPIO_A_COMMIT, 32'h1);
  endtask
  task automatic run_pins(input logic [9:0] p);
    closed <= ~p;
    acc = 16'h0;
    repeat (20) begin
      @(negedge clock);
      acc = acc | {txRequest, hostResetReq};
    end
    @(posedge clock);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    chk(remoteOutEn, 16'hffff);
    reset <= 1'h0;
    axr(`RPIO_A_CTRL);
    chk(lastData, 32'h0);
    axr(`RPIO_A_INCFG);
    chk(lastData, 32'h0);
    axw(`RPIO_A_CTRL, 32'h1);
    foreach (inRows[i]) begin
      closed[0] <= ~inRows[i][17];
      repeat (12) @(posedge clock);
      cfg_in(0, inRows[i][29:18]);
      run_pins({9'h0, inRows[i][16]});
      chk(acc, inRows[i][15:0]);
    end
    cfg_in(0, 12'h501);
    run_pins(10'h1);
    run_pins(10'h0);
    run_pins(10'h1);
    chk(acc, 16'h4000);
    axw(`RPIO_A_CTRL, 32'h0);
    cfg_in(0, 12'h101);
    run_pins(10'h1);
    run_pins(10'h0);
    chk(acc, 16'h0);
    axw(`RPIO_A_CTRL, 32'h1);
    cfg_in(0, 12'h806);
    closed <= ~10'h1;
    n = 0;
    repeat (120) begin
      @(negedge clock);
      if (txRequest.powerUp) n++;
    end
    chk(n, 3);
    @(posedge clock);
    cfg_in(1, 12'ha06);
    run_pins(10'h0);
    run_pins(10'h3);
    chk(acc, 16'h0080);
    axr(`RPIO_A_INLVL);
    chk(lastData, 32'h3);
    axr(8'h20);
    chk(lastResp, 2'h2);
    axw(8'h20, 32'h1);
    chk(lastResp, 2'h2);
    txStatus <= {1'h1, 1'h1, 1'h0, 4'h2, 4'h2, 256'h20};
    foreach (outRows[i]) begin
      axw(`RPIO_A_OUTCFG + 8'h0c, {19'h0, outRows[i][13:1]});
      axw(`RPIO_A_COMMIT, 32'h1);
      axr(`RPIO_A_OUTLVL);
      chk(pinLevel[3], outRows[i][0]);
      chk(lastData[3], outRows[i][0]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
